/* File: rdt_consts.vh */
`ifndef RDT_CONSTS_VH
`define RDT_CONSTS_VH

// ----------------------------------------------------------------
// register bus
// ----------------------------------------------------------------
`define RDT_AW              3
`define RDT_DW              16
`define RDT_ADDR_VALUE      3'h0
`define RDT_ADDR_MODE       3'h1
`define RDT_ADDR_START      3'h2
`define RDT_ADDR_IRQ        3'h3
`define RDT_ADDR_PORT       3'h4

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define RDT_MODE_W          8
`define RDT_MODE_RST        8'h00
`define RDT_MODE_OP         1:0
`define RDT_MODE_PULSE      2
`define RDT_MODE_GATE       4:3
`define RDT_MODE_RSVD       5
`define RDT_MODE_SRC        7:6
`define RDT_OP_TIMER        2'h0
`define RDT_GATE_LOW        2'h2
`define RDT_GATE_HIGH       2'h3
`define RDT_GATE_ON_BIT     1

// ----------------------------------------------------------------
// count sources
// ----------------------------------------------------------------
`define RDT_SRC_DIV2        2'h0
`define RDT_SRC_DIV16       2'h1
`define RDT_SRC_DIV64       2'h2
`define RDT_SRC_DIV512      2'h3
`define RDT_PRE_W           9
`define RDT_PRE_RST         9'h000
`define RDT_PRE_TOP2        0
`define RDT_PRE_TOP16       3
`define RDT_PRE_TOP64       5
`define RDT_PRE_TOP512      8

// ----------------------------------------------------------------
// single-bit control fields
// ----------------------------------------------------------------
`define RDT_START_BIT       0
`define RDT_IRQ_BIT         0
`define RDT_PORT_DIR_BIT    0
`define RDT_PORT_DATA_BIT   1
`define RDT_PORT_PIN_BIT    2

// ----------------------------------------------------------------
// counter values
// ----------------------------------------------------------------
`define RDT_CNT_ZERO        16'h0000
`define RDT_CNT_RELOAD_READ 16'hffff
`define RDT_WORD_ZERO       16'h0000

`endif

/* File: rdt_prescale.v */
`timescale 1ns/10ps
`default_nettype none
`include "rdt_consts.vh"

// ----------------------------------------------------------------
// free-running prescaler: one-cycle count-source enables
// ----------------------------------------------------------------
module rdt_prescale (
	input  wire       clock,
	input  wire       reset_n,
	input  wire [1:0] src_sel,
	output reg        src_tick
);

	reg [`RDT_PRE_W-1:0] pre_reg;
	wire [`RDT_PRE_W-1:0] pre_next;

	// runs all the time so the phase of the source does not depend on start
	assign pre_next = pre_reg + {{(`RDT_PRE_W-1){1'b0}}, 1'b1};

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pre_reg <= `RDT_PRE_RST;
		end else begin
			pre_reg <= pre_next;
		end
	end

	// tick when the low bits of the divider are all ones
	always @* begin
		case (src_sel)
			`RDT_SRC_DIV2:   src_tick = &pre_reg[`RDT_PRE_TOP2:0];
			`RDT_SRC_DIV16:  src_tick = &pre_reg[`RDT_PRE_TOP16:0];
			`RDT_SRC_DIV64:  src_tick = &pre_reg[`RDT_PRE_TOP64:0];
			`RDT_SRC_DIV512: src_tick = &pre_reg[`RDT_PRE_TOP512:0];
			default:         src_tick = 1'b0;
		endcase
	end

endmodule // rdt_prescale

`default_nettype wire

/* File: rdt_timer.v */
// Operation
// R1: mode bits 1:0 equal 00 select timer
// R2: software keeps mode bit 5 at zero
// R3: decrement per pulse; underflow reloads, sets request
// R4: value n gives request every n+1 pulses
// R5: write while halted loads counter and reload
// R6: write while counting loads reload only
// R7: software writes all 16 bits at once
// R8: count only while start flag is one
// R9: request stays set until accepted or cleared
// R10: reads return live counter; reload unreadable
// R11: read at reload moment returns ffff
// R12: halted write then read returns written value
// R13: gate bits 10 count low, 11 high
// R14: gated count freezes, resumes from held value
// R15: gate intervals last two source periods minimum
// R16: software sets gate pin as input
// R17: pulse select inverts output at each underflow
// R18: pulse select forces pin to output
// R19: output low while start flag is zero
// R20: gate and pulse output work together
// R21: source bits pick divide 2,16,64,512
// R22: source is one-cycle enable; request is level
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rdt_consts.vh"

module rdt_timer (
	input  wire                 clock,
	input  wire                 reset_n,
	input  wire [`RDT_AW-1:0]   bus_addr,
	input  wire [`RDT_DW-1:0]   bus_wdata,
	input  wire                 bus_write,
	input  wire                 bus_read,
	output reg  [`RDT_DW-1:0]   bus_rdata,
	input  wire                 gate_input_pin,
	input  wire                 toggle_output_pin_in,
	output wire                 toggle_output_pin_out,
	output wire                 toggle_output_pin_oe,
	output wire                 irq_request,
	input  wire                 irq_accept
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [`RDT_DW-1:0]     counter_reg;
	reg  [`RDT_DW-1:0]     counter_next;
	reg  [`RDT_DW-1:0]     reload_reg;
	reg  [`RDT_DW-1:0]     reload_next;
	reg  [`RDT_MODE_W-1:0] mode_reg;
	reg                    start_reg;
	reg                    irq_reg;
	reg                    irq_next;
	reg                    toggle_reg;
	reg                    toggle_next;
	reg                    port_dir_reg;
	reg                    port_data_reg;
	reg  [`RDT_DW-1:0]     rdata_next;

	wire                   src_tick;
	wire                   mode_timer;
	wire                   gate_on;
	wire                   gate_ok;
	wire                   count_en;
	wire                   underflow;
	wire                   pulse_sel;
	wire [`RDT_DW-1:0]     counter_dec;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire wr_value = bus_write && (bus_addr == `RDT_ADDR_VALUE);
	wire wr_mode  = bus_write && (bus_addr == `RDT_ADDR_MODE);
	wire wr_start = bus_write && (bus_addr == `RDT_ADDR_START);
	wire wr_irq   = bus_write && (bus_addr == `RDT_ADDR_IRQ);
	wire wr_port  = bus_write && (bus_addr == `RDT_ADDR_PORT);

	// ----------------------------------------------------------------
	// count source
	// ----------------------------------------------------------------
	rdt_prescale u_prescale (
		.clock    (clock),
		.reset_n  (reset_n),
		.src_sel  (mode_reg[`RDT_MODE_SRC]),  // see R21
		.src_tick (src_tick)                  // see R22
	);

	// ----------------------------------------------------------------
	// count enable
	// ----------------------------------------------------------------
	// other operating modes are not built here; the channel just idles
	assign mode_timer = (mode_reg[`RDT_MODE_OP] == `RDT_OP_TIMER);  // see R1

	// gate is on for codes 10 and 11; the low gate bit picks the level
	assign gate_on = mode_reg[`RDT_MODE_GATE] == `RDT_GATE_LOW ||
	                 mode_reg[`RDT_MODE_GATE] == `RDT_GATE_HIGH;   // see R13
	assign gate_ok = !gate_on ||
	                 (mode_reg[`RDT_MODE_GATE] == `RDT_GATE_HIGH ?
	                  gate_input_pin : !gate_input_pin);           // see R13

	// pulse only reaches the counter with start set and gate effective
	assign count_en  = src_tick && start_reg && mode_timer && gate_ok;  // see R8, R14
	assign underflow = count_en && (counter_reg == `RDT_CNT_ZERO);      // see R4
	assign counter_dec = counter_reg - {{(`RDT_DW-1){1'b0}}, 1'b1};

	// ----------------------------------------------------------------
	// counter and reload
	// ----------------------------------------------------------------
	always @* begin
		counter_next = counter_reg;
		reload_next  = reload_reg;
		if (wr_value) begin
			// one 16-bit access; byte writes are not offered
			reload_next = bus_wdata;                  // see R6, R7
		end
		if (count_en) begin
			if (underflow) begin
				// a reload written earlier takes effect here
				counter_next = reload_reg;            // see R3, R6
			end else begin
				counter_next = counter_dec;           // see R3
			end
			// when no pulse arrives the value is held as is
		end
		if (wr_value && !start_reg) begin
			counter_next = bus_wdata;                 // see R5
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			counter_reg <= `RDT_CNT_ZERO;
			reload_reg  <= `RDT_CNT_ZERO;
		end else begin
			counter_reg <= counter_next;
			reload_reg  <= reload_next;
		end
	end

	// ----------------------------------------------------------------
	// configuration and start flag
	// ----------------------------------------------------------------
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// reset also clears the reserved bit 5
			mode_reg      <= `RDT_MODE_RST;
			start_reg     <= 1'b0;
			port_dir_reg  <= 1'b0;
			port_data_reg <= 1'b0;
		end else begin
			if (wr_mode) begin
				mode_reg <= bus_wdata[`RDT_MODE_W-1:0];
			end
			if (wr_start) begin
				start_reg <= bus_wdata[`RDT_START_BIT];
			end
			if (wr_port) begin
				port_dir_reg  <= bus_wdata[`RDT_PORT_DIR_BIT];
				port_data_reg <= bus_wdata[`RDT_PORT_DATA_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt request
	// ----------------------------------------------------------------
	always @* begin
		irq_next = irq_reg;
		if (irq_accept) begin
			irq_next = 1'b0;                          // see R9
		end
		if (wr_irq) begin
			irq_next = bus_wdata[`RDT_IRQ_BIT];       // see R9
		end
		// an underflow in the clearing cycle must not be lost
		if (underflow) begin
			irq_next = 1'b1;                          // see R3, R9
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign irq_request = irq_reg;  // see R22

	// ----------------------------------------------------------------
	// pulse output
	// ----------------------------------------------------------------
	assign pulse_sel = mode_reg[`RDT_MODE_PULSE];

	always @* begin
		toggle_next = toggle_reg;
		if (!start_reg) begin
			toggle_next = 1'b0;                       // see R19
		end else if (underflow) begin
			toggle_next = !toggle_reg;                // see R17, R20
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			toggle_reg <= 1'b0;
		end else begin
			toggle_reg <= toggle_next;
		end
	end

	// pulse select overrides the direction bit; clearing it gives the pin back
	assign toggle_output_pin_out = pulse_sel ? (toggle_reg && start_reg)
	                                         : port_data_reg;           // see R18, R19
	assign toggle_output_pin_oe  = pulse_sel || port_dir_reg;           // see R18

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always @* begin
		rdata_next = `RDT_WORD_ZERO;
		case (bus_addr)
			`RDT_ADDR_VALUE: begin
				// the reload register has no read path at all
				if (underflow) begin
					rdata_next = `RDT_CNT_RELOAD_READ;  // see R11
				end else begin
					rdata_next = counter_reg;           // see R10, R12
				end
			end
			`RDT_ADDR_MODE: begin
				rdata_next[`RDT_MODE_W-1:0] = mode_reg;
			end
			`RDT_ADDR_START: begin
				rdata_next[`RDT_START_BIT] = start_reg;
			end
			`RDT_ADDR_IRQ: begin
				rdata_next[`RDT_IRQ_BIT] = irq_reg;
			end
			`RDT_ADDR_PORT: begin
				rdata_next[`RDT_PORT_DIR_BIT]  = port_dir_reg;
				rdata_next[`RDT_PORT_DATA_BIT] = port_data_reg;
				rdata_next[`RDT_PORT_PIN_BIT]  = toggle_output_pin_in;
			end
			default: begin
				rdata_next = `RDT_WORD_ZERO;
			end
		endcase
	end

	// data stand only in the cycle after the read strobe
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= `RDT_WORD_ZERO;
		end else if (bus_read) begin
			bus_rdata <= rdata_next;
		end else begin
			bus_rdata <= `RDT_WORD_ZERO;
		end
	end

endmodule // rdt_timer

`default_nettype wire

/* File: rdt_timer_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdt_consts.vh"
// ----------------------------------------
// port-level checks of the timer channel
// ----------------------------------------
module rdt_timer_properties (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic [2:0]  bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic        bus_write,
	input wire logic        bus_read,
	input wire logic [15:0] bus_rdata,
	input wire logic        gate_input_pin,
	input wire logic        toggle_output_pin_in,
	input wire logic        toggle_output_pin_out,
	input wire logic        toggle_output_pin_oe,
	input wire logic        irq_request,
	input wire logic        irq_accept
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_rd_idle; !$past(bus_read) |-> bus_rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_unmap; $past(bus_read) && $past(bus_addr) > `RDT_ADDR_PORT |-> bus_rdata == 0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_mode_rd; $past(bus_read) && $past(bus_addr) == `RDT_ADDR_MODE |-> bus_rdata[15:8] == 0; endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode upper bits set");
	property p_irq_rd;
		$past(bus_read) && $past(bus_addr) == `RDT_ADDR_IRQ |-> bus_rdata == {15'h0000, $past(irq_request)};
	endproperty
	a_irq_rd: assert property (p_irq_rd) else $error("request read mismatch");
	// a request may only drop through accept or a software write
	property p_irq_fall;
		$fell(irq_request) |-> $past(irq_accept) || $past(bus_write) && $past(bus_addr) == `RDT_ADDR_IRQ;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
	property p_pin_chg; $changed(toggle_output_pin_out) && !$past(bus_write) |-> irq_request; endproperty
	a_pin_chg: assert property (p_pin_chg) else $error("pin moved without underflow");
	property p_oe_chg; $changed(toggle_output_pin_oe) |-> $past(bus_write); endproperty
	a_oe_chg: assert property (p_oe_chg) else $error("enable moved without write");
	property p_pin_rd;
		$past(bus_read) && $past(bus_addr) == `RDT_ADDR_PORT |-> bus_rdata[2] == $past(toggle_output_pin_in);
	endproperty
	a_pin_rd: assert property (p_pin_rd) else $error("pin level read mismatch");
	c_irq: cover property ($rose(irq_request));
	c_pin: cover property ($rose(toggle_output_pin_out));
	c_acc: cover property (irq_request && irq_accept);
endmodule // rdt_timer_properties

bind rdt_timer rdt_timer_properties u_chk (.clock(clock), .reset_n(reset_n), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
	.gate_input_pin(gate_input_pin), .toggle_output_pin_in(toggle_output_pin_in),
	.toggle_output_pin_out(toggle_output_pin_out), .toggle_output_pin_oe(toggle_output_pin_oe),
	.irq_request(irq_request), .irq_accept(irq_accept));
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdt_consts.vh"
module tb_top;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        gate = 1'b0;
	logic        pin_in = 1'b0;
	logic        acc = 1'b0;
	wire  [15:0] rdata;
	wire         pout;
	wire         poe;
	wire         irq;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          seed = 74806;
	int          c, i, n, g;
	logic [15:0] v, v2;
	int          div [4] = '{2, 16, 64, 512};

	always #10 clock = ~clock;

	rdt_timer uut (.clock(clock), .reset_n(reset_n), .bus_addr(addr), .bus_wdata(wdata),
		.bus_write(wr_s), .bus_read(rd_s), .bus_rdata(rdata), .gate_input_pin(gate),
		.toggle_output_pin_in(pin_in), .toggle_output_pin_out(pout),
		.toggle_output_pin_oe(poe), .irq_request(irq), .irq_accept(acc));

	// ----------------------------------------
	// bus and check helpers
	// ----------------------------------------
	task automatic stop_test;
		$display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	// accepts the pending request, then counts cycles up to the next one
	task automatic rise;
		c = 0;
		acc <= 1'b1;
		do begin
			@(posedge clock);
			acc <= 1'b0;
			#1 c++;
			if (c > 3000) begin
				error_cnt++;
				stop_test();
			end
		end while (irq !== 1'b1);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		rd(`RDT_ADDR_MODE, v);
		chk(v, 16'h0000);
		rd(3'h7, v);
		chk(v, 16'h0000);
		for (i = 0; i < 4; i++) begin
			n = (i == 0) ? 0 : $random(seed) & 3;
			wr(`RDT_ADDR_START, 16'h0000);
			wr(`RDT_ADDR_VALUE, n[15:0]);
			rd(`RDT_ADDR_VALUE, v);
			chk(v, n[15:0]);
			wr(`RDT_ADDR_MODE, {8'h00, i[1:0], 6'h00});
			wr(`RDT_ADDR_START, 16'h0001);
			rise();
			rise();
			chk(c[15:0], 16'(div[i] * (n + 1)));
		end
		wr(`RDT_ADDR_MODE, 16'h0000);
		wr(`RDT_ADDR_START, 16'h0000);
		rd(`RDT_ADDR_VALUE, v);
		repeat (40) @(posedge clock);
		rd(`RDT_ADDR_VALUE, v2);
		chk(v2, v);
		// other operating modes leave the counter frozen even with start set
		wr(`RDT_ADDR_MODE, 16'h0001);
		wr(`RDT_ADDR_START, 16'h0001);
		rd(`RDT_ADDR_VALUE, v);
		repeat (40) @(posedge clock);
		rd(`RDT_ADDR_VALUE, v2);
		chk(v2, v);
		wr(`RDT_ADDR_START, 16'h0000);
		chk({15'h0000, irq}, 16'h0001);
		wr(`RDT_ADDR_IRQ, 16'h0000);
		rd(`RDT_ADDR_IRQ, v);
		chk(v, 16'h0000);
		wr(`RDT_ADDR_VALUE, 16'h0003);
		wr(`RDT_ADDR_MODE, 16'h0000);
		wr(`RDT_ADDR_START, 16'h0001);
		rise();
		wr(`RDT_ADDR_VALUE, 16'h0005);
		rise();
		// the old count of 3 still runs out: three ticks of two cycles after the write
		chk(c[15:0], 16'd6);
		rise();
		chk(c[15:0], 16'd12);
		wr(`RDT_ADDR_VALUE, 16'h0000);
		// let the zero reload take over so that every tick is a reload moment
		rise();
		rd(`RDT_ADDR_VALUE, v);
		@(posedge clock);
		rd(`RDT_ADDR_VALUE, v2);
		chk(v ^ v2, 16'hffff);
		for (g = 2; g < 4; g++) begin
			wr(`RDT_ADDR_START, 16'h0000);
			wr(`RDT_ADDR_VALUE, 16'd100);
			gate <= (g == 2);
			wr(`RDT_ADDR_MODE, {8'h00, 3'h0, g[1:0], 3'h0});
			wr(`RDT_ADDR_START, 16'h0001);
			repeat (20) @(posedge clock);
			rd(`RDT_ADDR_VALUE, v);
			chk(v, 16'd100);
			gate <= (g == 3);
			repeat (20) @(posedge clock);
			gate <= (g == 2);
			rd(`RDT_ADDR_VALUE, v);
			repeat (20) @(posedge clock);
			rd(`RDT_ADDR_VALUE, v2);
			chk(v2, v);
			chk({15'h0000, v < 16'd100}, 16'h0001);
			gate <= (g == 3);
			repeat (20) @(posedge clock);
			rd(`RDT_ADDR_VALUE, v2);
			chk({15'h0000, v2 < v}, 16'h0001);
		end
		wr(`RDT_ADDR_START, 16'h0000);
		wr(`RDT_ADDR_VALUE, 16'h0000);
		gate <= 1'b1;
		wr(`RDT_ADDR_MODE, 16'h001c);
		#1 chk({14'h0000, poe, pout}, 16'h0002);
		wr(`RDT_ADDR_START, 16'h0001);
		rise();
		v[0] = pout;
		rise();
		chk({15'h0000, pout}, {15'h0000, ~v[0]});
		wr(`RDT_ADDR_START, 16'h0000);
		#1 chk({15'h0000, pout}, 16'h0000);
		wr(`RDT_ADDR_MODE, 16'h0000);
		wr(`RDT_ADDR_PORT, 16'h0003);
		pin_in <= 1'b1;
		#1 chk({14'h0000, poe, pout}, 16'h0003);
		rd(`RDT_ADDR_PORT, v);
		chk(v, 16'h0007);
		wr(`RDT_ADDR_PORT, 16'h0000);
		#1 chk({15'h0000, poe}, 16'h0000);
		wr(`RDT_ADDR_START, 16'h0001);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(`RDT_ADDR_START, v);
		chk(v, 16'h0000);
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
